// ---- hcb_regs.vh ----
/*
 * hcb_regs.vh
 * Constants for the Hall-commutated alternating-recirculation gate
 * pattern block: brake mode codes, field widths and timing counts.
 * Assumes inclusion by bare name from the block's design files.
 */
`ifndef HCB_REGS_VH
`define HCB_REGS_VH

// brake mode select codes
`define HCB_BRAKE_LOW       2'h0
`define HCB_BRAKE_HIGH      2'h1
`define HCB_BRAKE_ALT       2'h2
`define HCB_BRAKE_HIZ       2'h3

// field widths
`define HCB_MODE_W          2
`define HCB_DT_W            8

// dead-time counter reset and step
`define HCB_DT_ZERO         8'h00
`define HCB_DT_ONE          8'h01

// forbidden hall codes
`define HCB_HALL_ALL_ONE    3'h7
`define HCB_HALL_ALL_ZERO   3'h0

// clock period in ns and shortest gap between opposed switches
`define HCB_CLK_PERIOD_NS   4
`define HCB_MIN_GAP_NS      4
`define HCB_MIN_GAP_CYC     ((`HCB_MIN_GAP_NS + `HCB_CLK_PERIOD_NS - 1) / `HCB_CLK_PERIOD_NS)

`endif

// ---- hcb_deadtime.v ----
/*
 * hcb_deadtime.v
 * One phase leg: turns requested high/low gate levels into registered
 * gate outputs, switching off at once and holding a dead time before
 * any switch is turned on after a turn-off.
 * Assumes requests never ask for both switches of the leg at once.
 */
`timescale 1ns/1ps
`include "hcb_regs.vh"

module hcb_deadtime (
	input  wire                 clk_i,          // core clock
	input  wire                 resetn_i,       // sync reset, active low
	input  wire                 ce_i,           // clock enable
	input  wire                 high_req_i,     // wanted high gate level
	input  wire                 low_req_i,      // wanted low gate level
	input  wire [`HCB_DT_W-1:0] dead_cycles_i,  // dead time in cycles
	output reg                  gate_high_o,    // high switch gate
	output reg                  gate_low_o      // low switch gate
);

	reg [`HCB_DT_W-1:0] dead_cnt;
	wire                turn_off;

	assign turn_off = (gate_high_o & ~high_req_i) | (gate_low_o & ~low_req_i);

	always @(posedge clk_i) begin
		if (!resetn_i) begin
			gate_high_o <= 1'b0;
			gate_low_o  <= 1'b0;
			dead_cnt    <= `HCB_DT_ZERO;
		end else if (ce_i) begin
			if (turn_off) begin
				// conflicting switch off first, then wait
				gate_high_o <= gate_high_o & high_req_i; // see (R14)
				gate_low_o  <= gate_low_o & low_req_i;   // see (R14)
				dead_cnt    <= dead_cycles_i;            // see (R17)
			end else if (dead_cnt != `HCB_DT_ZERO) begin
				dead_cnt <= dead_cnt - `HCB_DT_ONE;      // see (R17)
			end else begin
				gate_high_o <= high_req_i;
				gate_low_o  <= low_req_i;
			end
		end
	end

endmodule // hcb_deadtime

// ---- hcb_gate_pattern.v ----
/*
 * hcb_gate_pattern.v
 * Single-PWM Hall-commutated gate pattern with alternating
 * recirculation (twelve states) and brake handling for a three-phase
 * bridge. Configuration and fault bits are plain ports.
 * Assumes a controller drives PWM, direction, Hall replica and brake
 * request pins asynchronously; fault inputs and configuration come
 * from logic on clk_i.
 */
`timescale 1ns/1ps
`include "hcb_regs.vh"

////////////////////////////////////////////////////////////////////////
// Summary of operation
// (R1) twelve states: six low-on then six high-on
// (R2) low-on half: table of pulsed and on phases
// (R3) high-on half: swapped roles, low gets PWM
// (R4) hall 111 or 000 floats all phases
// (R5) diode freewheeling forces inverted-PWM gates low
// (R6) brake request low overrides pattern by mode
// (R7) overcurrent and watchdog faults also brake, enabled
// (R8) controller keeps brake request high normally
// (R9) low brake: all lows on, highs off
// (R10) high brake: all highs on, lows off
// (R11) alternate brake toggles side each event
// (R12) non-power brake: all six gates off
// (R13) brake config changes apply to later events
// (R14) conflicting switches off, dead time, then brake
// (R15) controller supplies PWM on phase A input
// (R16) controller drives direction and Hall replica inputs
// (R17) automatic dead time from rising/hall settings
// (R18) brake release resumes normal commutation pattern
// (R19) start low half, swap each electrical rotation
// (R20) async inputs pass two flip-flop stages
module hcb_gate_pattern (
	input  wire                   clk_i,                    // core clock
	input  wire                   resetn_i,                 // sync reset
	input  wire                   ce_i,                     // clock enable
	input  wire                   pwm_input_phase_a_i,      // PWM pin
	input  wire                   direction_select_input_i, // rotation dir
	input  wire [2:0]             hall_replica_inputs_i,    // hall [A,B,C]
	input  wire                   brake_request_n_i,        // brake pin
	input  wire                   overcurrent_fault_i,      // sense fault
	input  wire                   watchdog_fault_i,         // watchdog fault
	input  wire                   ocp_brake_en_i,           // ocp brakes
	input  wire                   wdt_brake_en_i,           // wdt brakes
	input  wire [`HCB_MODE_W-1:0] brake_mode_i,             // brake mode
	input  wire                   freewheel_mode_select_i,  // 1 = active
	input  wire [`HCB_DT_W-1:0]   rising_dead_time_i,       // pwm dead time
	input  wire [`HCB_DT_W-1:0]   hall_mode_dead_time_i,    // commut. dt
	output wire                   gate_high_phase_a_o,      // phase A high
	output wire                   gate_low_phase_a_o,       // phase A low
	output wire                   gate_high_phase_b_o,      // phase B high
	output wire                   gate_low_phase_b_o,       // phase B low
	output wire                   gate_high_phase_c_o,      // phase C high
	output wire                   gate_low_phase_c_o,       // phase C low
	output reg                    brake_active_o,           // braking now
	output reg                    high_half_o               // high-on half
);

	////////////////////////////////////////////////////////////////////
	// pulsed phase per effective code, one-hot {A,B,C}
	function [2:0] pulse_phase;
		input [2:0] code;
		begin
			case (code)
				3'h5:    pulse_phase = 3'h4;
				3'h4:    pulse_phase = 3'h2;
				3'h6:    pulse_phase = 3'h2;
				3'h2:    pulse_phase = 3'h1;
				3'h3:    pulse_phase = 3'h1;
				3'h1:    pulse_phase = 3'h4;
				default: pulse_phase = 3'h0;
			endcase
		end
	endfunction

	// companion phase per effective code, one-hot {A,B,C}
	function [2:0] return_phase;
		input [2:0] code;
		begin
			case (code)
				3'h5:    return_phase = 3'h1;
				3'h4:    return_phase = 3'h1;
				3'h6:    return_phase = 3'h4;
				3'h2:    return_phase = 3'h4;
				3'h3:    return_phase = 3'h2;
				3'h1:    return_phase = 3'h2;
				default: return_phase = 3'h0;
			endcase
		end
	endfunction

	function is_forbidden;
		input [2:0] code;
		begin
			is_forbidden = (code == `HCB_HALL_ALL_ONE) ||
				(code == `HCB_HALL_ALL_ZERO);
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// input synchronisers
	reg [2:0] hall_meta;
	reg [2:0] hall_sync;
	reg       dir_meta;
	reg       dir_sync;
	reg       brk_meta;
	reg       brk_n_sync;
	reg       pwm_meta;
	reg       pwm_sync;

	always @(posedge clk_i) begin
		if (!resetn_i) begin
			hall_meta  <= 3'h0;
			hall_sync  <= 3'h0;
			dir_meta   <= 1'b1;
			dir_sync   <= 1'b1;
			brk_meta   <= 1'b1;
			brk_n_sync <= 1'b1;
			pwm_meta   <= 1'b0;
			pwm_sync   <= 1'b0;
		end else if (ce_i) begin
			hall_meta  <= hall_replica_inputs_i;    // see (R20)
			hall_sync  <= hall_meta;                // see (R20)
			dir_meta   <= direction_select_input_i; // see (R20)
			dir_sync   <= dir_meta;                 // see (R20)
			brk_meta   <= brake_request_n_i;        // see (R20)
			brk_n_sync <= brk_meta;                 // see (R20)
			pwm_meta   <= pwm_input_phase_a_i;
			pwm_sync   <= pwm_meta;
		end
	end

	////////////////////////////////////////////////////////////////////
	// effective code and rotation tracking
	wire [2:0] eff_code;
	reg  [2:0] eff_prev;
	reg  [2:0] half_start;
	reg        start_valid;
	reg        left_start;
	wire       code_valid;
	wire       code_change;

	// direction low inverts the hall code
	assign eff_code    = dir_sync ? hall_sync : ~hall_sync; // see (R2)
	assign code_valid  = ~is_forbidden(eff_code);
	assign code_change = (eff_code != eff_prev);

	always @(posedge clk_i) begin
		if (!resetn_i) begin
			eff_prev    <= 3'h0;
			half_start  <= 3'h0;
			start_valid <= 1'b0;
			left_start  <= 1'b0;
			high_half_o <= 1'b0;                 // see (R19)
		end else if (ce_i) begin
			eff_prev <= eff_code;
			if (code_valid) begin
				if (!start_valid) begin
					half_start  <= eff_code;
					start_valid <= 1'b1;
					left_start  <= 1'b0;
				end else if (eff_code != half_start) begin
					left_start <= 1'b1;
				end else if (left_start) begin
					// back at start code: one rotation done
					high_half_o <= ~high_half_o; // see (R1) (R19)
					left_start  <= 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// brake trigger, mode latch and alternation
	wire       brake_trig;
	reg  [1:0] brake_mode_q;
	reg        alt_use_high;

	assign brake_trig = ~brk_n_sync |                        // see (R6)
		(ocp_brake_en_i & overcurrent_fault_i) |             // see (R7)
		(wdt_brake_en_i & watchdog_fault_i);                 // see (R7)

	always @(posedge clk_i) begin
		if (!resetn_i) begin
			brake_active_o <= 1'b0;
			brake_mode_q   <= `HCB_BRAKE_LOW;
			alt_use_high   <= 1'b1;
		end else if (ce_i) begin
			brake_active_o <= brake_trig;                    // see (R18)
			if (brake_trig && !brake_active_o) begin
				// mode sampled per event
				brake_mode_q <= brake_mode_i;                // see (R13)
				if (brake_mode_i == `HCB_BRAKE_ALT) begin
					alt_use_high <= ~alt_use_high;           // see (R11)
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// gate requests
	reg  [2:0] next_high_req;
	reg  [2:0] next_low_req;
	reg  [2:0] pulse_ph;
	reg  [2:0] ret_ph;
	reg        pwm_inv;
	reg        alt_high_now;

	always @* begin
		pulse_ph      = pulse_phase(eff_code);
		ret_ph        = return_phase(eff_code);
		pwm_inv       = freewheel_mode_select_i & ~pwm_sync; // see (R5)
		alt_high_now  = alt_use_high;
		next_high_req = 3'h0;
		next_low_req  = 3'h0;
		if (brake_active_o) begin
			case (brake_mode_q)
				`HCB_BRAKE_LOW: begin
					next_low_req = 3'h7;                     // see (R9)
				end
				`HCB_BRAKE_HIGH: begin
					next_high_req = 3'h7;                    // see (R10)
				end
				`HCB_BRAKE_ALT: begin
					if (alt_high_now) begin
						next_high_req = 3'h7;                // see (R11)
					end else begin
						next_low_req = 3'h7;                 // see (R11)
					end
				end
				default: begin
					next_high_req = 3'h0;                    // see (R12)
					next_low_req  = 3'h0;                    // see (R12)
				end
			endcase
		end else if (!code_valid) begin
			next_high_req = 3'h0;                            // see (R4)
			next_low_req  = 3'h0;                            // see (R4)
		end else if (!high_half_o) begin
			// pulsed phase modulated, companion low held on
			next_high_req = pulse_ph & {3{pwm_sync}};        // see (R2)
			next_low_req  = (pulse_ph & {3{pwm_inv}}) | ret_ph; // see (R2)
		end else begin
			// companion low modulated, pulsed phase high held on
			next_high_req = pulse_ph | (ret_ph & {3{pwm_inv}}); // see (R3)
			next_low_req  = ret_ph & {3{pwm_sync}};          // see (R3)
		end
	end

	////////////////////////////////////////////////////////////////////
	// dead-time selection and phase legs
	wire                 commut_evt;
	reg  [`HCB_DT_W-1:0] dead_sel;
	wire [2:0]           gate_high;
	wire [2:0]           gate_low;

	assign commut_evt = code_change | (brake_trig != brake_active_o);

	always @* begin
		if (commut_evt || brake_active_o) begin
			dead_sel = hall_mode_dead_time_i;                // see (R17)
		end else begin
			dead_sel = rising_dead_time_i;                   // see (R17)
		end
	end

	hcb_deadtime u_leg_a (
		.clk_i         (clk_i),
		.resetn_i      (resetn_i),
		.ce_i          (ce_i),
		.high_req_i    (next_high_req[2]),
		.low_req_i     (next_low_req[2]),
		.dead_cycles_i (dead_sel),
		.gate_high_o   (gate_high[2]),
		.gate_low_o    (gate_low[2])
	);

	hcb_deadtime u_leg_b (
		.clk_i         (clk_i),
		.resetn_i      (resetn_i),
		.ce_i          (ce_i),
		.high_req_i    (next_high_req[1]),
		.low_req_i     (next_low_req[1]),
		.dead_cycles_i (dead_sel),
		.gate_high_o   (gate_high[1]),
		.gate_low_o    (gate_low[1])
	);

	hcb_deadtime u_leg_c (
		.clk_i         (clk_i),
		.resetn_i      (resetn_i),
		.ce_i          (ce_i),
		.high_req_i    (next_high_req[0]),
		.low_req_i     (next_low_req[0]),
		.dead_cycles_i (dead_sel),
		.gate_high_o   (gate_high[0]),
		.gate_low_o    (gate_low[0])
	);

	assign gate_high_phase_a_o = gate_high[2];
	assign gate_low_phase_a_o  = gate_low[2];
	assign gate_high_phase_b_o = gate_high[1];
	assign gate_low_phase_b_o  = gate_low[1];
	assign gate_high_phase_c_o = gate_high[0];
	assign gate_low_phase_c_o  = gate_low[0];

endmodule // hcb_gate_pattern

// ---- hcb_gate_pattern_properties.sv ----
/* Port checker for hcb_gate_pattern: leg safety, brake and pattern.
   Assumes bind onto the design, one clock, sync active-low reset. */
`timescale 1ns/1ps
`include "hcb_regs.vh"
module hcb_props (
	input wire                   clk_i,                   // clock
	input wire                   resetn_i,                // reset
	input wire [2:0]             hall_replica_inputs_i,   // hall pins
	input wire                   brake_request_n_i,       // brake pin
	input wire                   overcurrent_fault_i,     // ocp fault
	input wire                   watchdog_fault_i,        // wdt fault
	input wire                   ocp_brake_en_i,          // ocp enable
	input wire                   wdt_brake_en_i,          // wdt enable
	input wire [`HCB_MODE_W-1:0] brake_mode_i,            // brake mode
	input wire                   freewheel_mode_select_i, // freewheel
	input wire                   gate_high_phase_a_o,     // gate
	input wire                   gate_low_phase_a_o,      // gate
	input wire                   gate_high_phase_b_o,     // gate
	input wire                   gate_low_phase_b_o,      // gate
	input wire                   gate_high_phase_c_o,     // gate
	input wire                   gate_low_phase_c_o,      // gate
	input wire                   brake_active_o,          // braking
	input wire                   high_half_o              // half
);
	wire [5:0] g = {gate_high_phase_a_o, gate_low_phase_a_o,
		gate_high_phase_b_o, gate_low_phase_b_o,
		gate_high_phase_c_o, gate_low_phase_c_o};
	wire [2:0] hi = {g[5], g[3], g[1]};
	wire [2:0] lo = {g[4], g[2], g[0]};
	wire       flt = (overcurrent_fault_i && ocp_brake_en_i) ||
		(watchdog_fault_i && wdt_brake_en_i);
	wire       trig = !brake_request_n_i || flt;
	wire       bad = hall_replica_inputs_i == 3'h7 ||
		hall_replica_inputs_i == 3'h0;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	////////////////////////////////////////////////////////////////////
	no_shoot_a: assert property ((hi & lo) == 3'h0)
		else $error("both switches of one leg on");
	dead_gap_a: assert property (
		((hi & $past(lo)) | (lo & $past(hi))) == 3'h0)
		else $error("leg switched over without a gap");
	reset_clears_a: assert property (disable iff (1'b0)
		!resetn_i |=> g == 6'h00 && !brake_active_o && !high_half_o)
		else $error("outputs not cleared by reset");
	forbidden_float_a: assert property (
		(!trig && bad) [*5] |-> g == 6'h00)
		else $error("forbidden hall code drives a gate");
	brake_pin_a: assert property (
		(!brake_request_n_i) [*4] |-> brake_active_o)
		else $error("brake pin low but no braking");
	fault_brake_a: assert property (flt |=> brake_active_o)
		else $error("enabled fault did not brake");
	no_brake_a: assert property ((!trig) [*4] |-> !brake_active_o)
		else $error("braking without a trigger");
	// mode is latched on the edge that raises brake_active_o
	brake_low_a: assert property ($rose(brake_active_o) &&
		$past(brake_mode_i) == `HCB_BRAKE_LOW |-> ##[0:300]
		(g == 6'h15 || !brake_active_o))
		else $error("low-side brake pattern missing");
	brake_high_a: assert property ($rose(brake_active_o) &&
		$past(brake_mode_i) == `HCB_BRAKE_HIGH |-> ##[0:300]
		(g == 6'h2A || !brake_active_o))
		else $error("high-side brake pattern missing");
	// legs drop their gates one edge after the brake flag rises
	brake_hiz_a: assert property ($rose(brake_active_o) &&
		$past(brake_mode_i) == `HCB_BRAKE_HIZ |=> g == 6'h00)
		else $error("non-power brake left a gate on");
	diode_one_a: assert property ((!freewheel_mode_select_i &&
		!brake_active_o && !high_half_o) [*5] |-> $countones(lo) <= 1)
		else $error("inverse PWM gate on in diode mode");
endmodule // hcb_props

bind hcb_gate_pattern hcb_props u_props (
	.clk_i(clk_i), .resetn_i(resetn_i),
	.hall_replica_inputs_i(hall_replica_inputs_i),
	.brake_request_n_i(brake_request_n_i),
	.overcurrent_fault_i(overcurrent_fault_i),
	.watchdog_fault_i(watchdog_fault_i),
	.ocp_brake_en_i(ocp_brake_en_i), .wdt_brake_en_i(wdt_brake_en_i),
	.brake_mode_i(brake_mode_i),
	.freewheel_mode_select_i(freewheel_mode_select_i),
	.gate_high_phase_a_o(gate_high_phase_a_o),
	.gate_low_phase_a_o(gate_low_phase_a_o),
	.gate_high_phase_b_o(gate_high_phase_b_o),
	.gate_low_phase_b_o(gate_low_phase_b_o),
	.gate_high_phase_c_o(gate_high_phase_c_o),
	.gate_low_phase_c_o(gate_low_phase_c_o),
	.brake_active_o(brake_active_o), .high_half_o(high_half_o)
);

// ---- hcb_ctl_model.sv ----
/* Controller model: drives PWM, direction, hall and brake pins.
   Assumes bench commands; pins change on falling clock edges. */
`timescale 1ns/1ps
module hcb_ctl_model (
	input  wire       clk_i,            // clock
	input  wire [2:0] hall_i,           // hall code to replicate
	input  wire       dir_i,            // direction
	input  wire       brake_i,          // 1 = request braking
	input  wire       pwm_i,            // static PWM level
	input  wire       run_i,            // 1 = free-running PWM
	output reg  [2:0] hall_o = 3'h0,    // hall pins
	output reg        dir_o = 1'b1,     // direction pin
	output reg        brake_n_o = 1'b1, // brake request pin
	output reg        pwm_o = 1'b0      // PWM pin
);
	reg [3:0] cnt = 4'h0;

	always @(negedge clk_i) begin
		cnt       <= cnt + 4'h1;
		pwm_o     <= run_i ? cnt[3] : pwm_i;
		dir_o     <= dir_i;
		hall_o    <= hall_i;
		brake_n_o <= !brake_i;
	end
endmodule // hcb_ctl_model

// ---- hcb_gate_pattern_test.sv ----
/* Self-checking bench for hcb_gate_pattern with controller model.
   Assumes design, checker and model files compiled first. */
`timescale 1ns/1ps
`include "hcb_regs.vh"
module hcb_gate_pattern_test;
	reg        clk = 1'b0;
	reg        resetn = 1'b0;
	reg  [2:0] hall = 3'h0;
	reg        dir = 1'b1;
	reg        brk = 1'b0;
	reg        pwm = 1'b0;
	reg        run = 1'b0;
	reg        fw = 1'b1;
	reg  [1:0] mode = 2'h0;
	reg  [1:0] flt = 2'h0;
	reg  [1:0] en = 2'h0;
	reg  [7:0] nrm;
	wire [2:0] hp;
	wire       dp, bp, pp, ba, hh;
	wire [5:0] g;
	wire [7:0] obs = {g, ba, hh};
	integer    err_total = 0, tests_run = 0, cyc = 0, i, k, p;

	hcb_ctl_model u_ctl (.clk_i(clk), .hall_i(hall), .dir_i(dir),
		.brake_i(brk), .pwm_i(pwm), .run_i(run), .hall_o(hp),
		.dir_o(dp), .brake_n_o(bp), .pwm_o(pp));
	hcb_gate_pattern dut (.clk_i(clk), .resetn_i(resetn), .ce_i(1'b1),
		.pwm_input_phase_a_i(pp), .direction_select_input_i(dp),
		.hall_replica_inputs_i(hp), .brake_request_n_i(bp),
		.overcurrent_fault_i(flt[0]), .watchdog_fault_i(flt[1]),
		.ocp_brake_en_i(en[0]), .wdt_brake_en_i(en[1]),
		.brake_mode_i(mode), .freewheel_mode_select_i(fw),
		.rising_dead_time_i(8'h02), .hall_mode_dead_time_i(8'h03),
		.gate_high_phase_a_o(g[5]), .gate_low_phase_a_o(g[4]),
		.gate_high_phase_b_o(g[3]), .gate_low_phase_b_o(g[2]),
		.gate_high_phase_c_o(g[1]), .gate_low_phase_c_o(g[0]),
		.brake_active_o(ba), .high_half_o(hh));

	always #2 clk = ~clk;

	////////////////////////////////////////////////////////////////////
	function [2:0] sq(input integer n);
		case (n % 6)
		0: sq = 3'h5;
		1: sq = 3'h4;
		2: sq = 3'h6;
		3: sq = 3'h2;
		4: sq = 3'h3;
		default: sq = 3'h1;
		endcase
	endfunction

	// gates {ha,la,hb,lb,hc,lc}: a pulsed/high-on phase, b low-on/pulsed
	function [5:0] exp_g(input [2:0] c, input d, h, pw, f);
		reg [3:0] ab;
		reg [5:0] r;
		begin
			case (d ? c : ~c)
			3'h5: ab = 4'h2;
			3'h4: ab = 4'h6;
			3'h6: ab = 4'h4;
			3'h2: ab = 4'h8;
			3'h3: ab = 4'h9;
			default: ab = 4'h1;
			endcase
			r = 6'h00;
			if (h) begin
				r[5 - 2 * ab[3:2]] = 1'b1;
				r[5 - 2 * ab[1:0]] = !pw && f;
				r[4 - 2 * ab[1:0]] = pw;
			end else begin
				r[5 - 2 * ab[3:2]] = pw;
				r[4 - 2 * ab[3:2]] = !pw && f;
				r[4 - 2 * ab[1:0]] = 1'b1;
			end
			exp_g = r;
		end
	endfunction

	// brake event table {mode, expected gates}
	function [7:0] bk(input integer n);
		case (n)
		0, 2: bk = {`HCB_BRAKE_ALT, 6'h15};
		1: bk = {`HCB_BRAKE_ALT, 6'h2A};
		3: bk = {`HCB_BRAKE_LOW, 6'h15};
		4: bk = {`HCB_BRAKE_HIGH, 6'h2A};
		default: bk = {`HCB_BRAKE_HIZ, 6'h00};
		endcase
	endfunction

	task chk(input [7:0] got, input [7:0] want);
		begin
			tests_run = tests_run + 1;
			if (got !== want) begin
				err_total = err_total + 1;
				$display("BAD %0t got %h want %h", $time, got, want);
			end
		end
	endtask

	task settle;
		repeat (20) @(negedge clk);
	endtask

	task rst;
		begin
			resetn <= 1'b0;
			repeat (16) @(negedge clk);
			resetn <= 1'b1;
		end
	endtask

	task give_verdict;
		begin
			$display("mismatches %0d checks %0d", err_total, tests_run);
			if (err_total == 0 && tests_run > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask

	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 6000) begin
			err_total = err_total + 1;
			give_verdict;
		end
	end

	////////////////////////////////////////////////////////////////////
	initial begin
		rst;
		@(negedge clk);
		chk(obs, 8'h00);
		for (k = 0; k < 2; k = k + 1) begin
			dir <= (k == 0);
			fw <= (k == 0);
			hall <= 3'h7;
			rst;
			settle;
			chk(obs, 8'h00);
			for (i = 0; i < 13; i = i + 1) begin
				for (p = 0; p < 2; p = p + 1) begin
					hall <= sq(i);
					pwm <= (p == 1);
					settle;
					chk(obs,
						{exp_g(sq(i), dir, i / 6 == 1, pwm, fw),
						1'b0, i / 6 == 1});
				end
			end
		end
		fw <= 1'b1;
		settle;
		nrm = {exp_g(3'h5, 1'b0, 1'b0, 1'b1, 1'b1), 2'h0};
		for (i = 0; i < 6; i = i + 1) begin
			mode <= bk(i) >> 6;
			brk <= 1'b1;
			settle;
			chk(obs,
				{bk(i) & 8'h3F, 2'h2});
			mode <= ~(bk(i) >> 6);
			settle;
			chk(obs, {bk(i) & 8'h3F, 2'h2});
			brk <= 1'b0;
			settle;
			chk(obs, nrm);
		end
		mode <= `HCB_BRAKE_HIGH;
		for (i = 0; i < 2; i = i + 1) begin
			flt <= 2'h1 << i;
			settle;
			chk(obs, nrm);
			en <= 2'h1 << i;
			settle;
			chk(obs, 8'hAA);
			flt <= 2'h0;
			en <= 2'h0;
			settle;
			chk(obs, nrm);
		end
		// pwm edge: pulsed high off, low on after rising dead time + 1
		pwm <= 1'b0;
		repeat (6) @(negedge clk);
		chk(obs,
			{exp_g(3'h5, 1'b0, 1'b0, 1'b1, 1'b1) &
			exp_g(3'h5, 1'b0, 1'b0, 1'b0, 1'b1), 2'h0});
		@(negedge clk);
		chk(obs,
			{exp_g(3'h5, 1'b0, 1'b0, 1'b0, 1'b1), 2'h0});
		run <= 1'b1;
		repeat (300) @(negedge clk);
		give_verdict;
	end
endmodule // hcb_gate_pattern_test
